/* File: pkg/lpddr2_state_defines.svh */
// Timing counts, command codes and geometry for the power and bank state model
`ifndef LPDDR2_STATE_DEFINES_SVH
`define LPDDR2_STATE_DEFINES_SVH
`define NUM_BANKS 8
`define BANK_W 3
`define CNT_W 8
// Timing figures in memory clock cycles (rising edges of mem_ck)
`define T_RP_CK 8'h04
`define T_RCD_CK 8'h04
`define T_MRW_CK 8'h05
`define T_MRR_CK 8'h02
`define T_RFCPB_CK 8'h10
`define T_RFCAB_CK 8'h20
`define T_XP_CK 8'h03
`define T_XSR_CK 8'h10
`define T_BURST_CK 8'h04
// Decoded command codes on the command port
`define CMD_NOP 4'h0
`define CMD_MRW 4'h1
`define CMD_MRR 4'h2
`define CMD_REFPB 4'h3
`define CMD_REFAB 4'h4
`define CMD_ACT 4'h5
`define CMD_WR 4'h6
`define CMD_RD 4'h7
`define CMD_PRE 4'h8
`define CMD_BST 4'h9
`define CMD_SREF 4'hA
`define CMD_DPD 4'hB
`define CMD_RESET 4'hC
`endif

/* File: pkg/lpddr2_state_pkg.sv */
// Types for the power and bank state model
package lpddr2_state_pkg;
	typedef enum logic [10:0] {
		DEV_POWER_ON = 11'h001,
		DEV_RESETTING = 11'h002,
		DEV_IDLE = 11'h004,
		DEV_ACTIVE = 11'h008,
		DEV_ACT_PD = 11'h010,
		DEV_IDLE_PD = 11'h020,
		DEV_RST_PD = 11'h040,
		DEV_SREF = 11'h080,
		DEV_DPD = 11'h100,
		DEV_MRW = 11'h200,
		DEV_BUSY = 11'h400
	} dev_state_t;
	typedef enum logic [7:0] {
		BK_IDLE = 8'h01,
		BK_ACTIVATING = 8'h02,
		BK_ACTIVE = 8'h04,
		BK_READING = 8'h08,
		BK_WRITING = 8'h10,
		BK_PRECHARGING = 8'h20,
		BK_AP_BURST = 8'h40,
		BK_REFRESHING = 8'h80
	} bank_state_t;
endpackage

/* File: verilog/lpddr2_bank_fsm.sv */
// One bank's state machine with its timing counter
`timescale 1ns/1ps
`include "lpddr2_state_defines.svh"
module lpddr2_bank_fsm (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic ck_tick,
	input wire logic cmd_valid,
	input wire logic sel,
	input wire logic [3:0] cmd,
	input wire logic auto_pre,
	input wire logic pre_all,
	input wire logic bst_hit,
	output lpddr2_state_pkg::bank_state_t state,
	output logic open_row
);
	lpddr2_state_pkg::bank_state_t state_r, state_nxt;
	logic [`CNT_W-1:0] cnt_r, cnt_nxt;
	logic hit;
	assign state = state_r;
	assign open_row = (state_r != lpddr2_state_pkg::BK_IDLE) &&
		(state_r != lpddr2_state_pkg::BK_PRECHARGING);
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		hit = cmd_valid && sel;
		if (ck_tick && cnt_r != '0)
			cnt_nxt = cnt_r - 1'b1;
		case (state_r)
			lpddr2_state_pkg::BK_IDLE: begin
				if (hit && cmd == `CMD_ACT) begin
					state_nxt = lpddr2_state_pkg::BK_ACTIVATING;
					cnt_nxt = `T_RCD_CK;
				end else if (hit && cmd == `CMD_REFPB) begin
					state_nxt = lpddr2_state_pkg::BK_REFRESHING;
					cnt_nxt = `T_RFCPB_CK;
				end else if ((hit || (cmd_valid && pre_all)) && cmd == `CMD_PRE) begin
					state_nxt = lpddr2_state_pkg::BK_PRECHARGING;
					cnt_nxt = `T_RP_CK;
				end
			end
			lpddr2_state_pkg::BK_ACTIVE, lpddr2_state_pkg::BK_READING,
			lpddr2_state_pkg::BK_WRITING: begin
				if ((hit || (cmd_valid && pre_all)) && cmd == `CMD_PRE) begin
					state_nxt = lpddr2_state_pkg::BK_PRECHARGING;
					cnt_nxt = `T_RP_CK;
				end else if (hit && (cmd == `CMD_RD || cmd == `CMD_WR)) begin
					cnt_nxt = auto_pre ? `T_BURST_CK + `T_RP_CK : `T_BURST_CK;
					if (auto_pre)
						state_nxt = lpddr2_state_pkg::BK_AP_BURST;
					else if (cmd == `CMD_RD)
						state_nxt = lpddr2_state_pkg::BK_READING;
					else
						state_nxt = lpddr2_state_pkg::BK_WRITING;
				end else if (state_r != lpddr2_state_pkg::BK_ACTIVE &&
						(bst_hit || (cnt_r == '0))) begin
					state_nxt = lpddr2_state_pkg::BK_ACTIVE;
				end
			end
			lpddr2_state_pkg::BK_ACTIVATING:
				if (cnt_r == '0)
					state_nxt = lpddr2_state_pkg::BK_ACTIVE;
			lpddr2_state_pkg::BK_PRECHARGING, lpddr2_state_pkg::BK_AP_BURST,
			lpddr2_state_pkg::BK_REFRESHING:
				if (cnt_r == '0)
					state_nxt = lpddr2_state_pkg::BK_IDLE;
			default: state_nxt = lpddr2_state_pkg::BK_IDLE;
		endcase
	end
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= lpddr2_state_pkg::BK_IDLE;
			cnt_r <= '0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	a_pre_to_idle: assert property (@(posedge sys_clk) disable iff (!arst_n)
		state_r == lpddr2_state_pkg::BK_PRECHARGING && cnt_r == '0 |=>
		state_r == lpddr2_state_pkg::BK_IDLE)
		else $error("precharge did not end in idle");
	a_act_open: assert property (@(posedge sys_clk) disable iff (!arst_n)
		state_r == lpddr2_state_pkg::BK_IDLE && hit && cmd == `CMD_ACT |=>
		state_r == lpddr2_state_pkg::BK_ACTIVATING)
		else $error("activate did not open row");
	a_rcd_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
		state_r == lpddr2_state_pkg::BK_ACTIVATING && cnt_r != '0 |=>
		state_r == lpddr2_state_pkg::BK_ACTIVATING)
		else $error("activating left early");
endmodule // lpddr2_bank_fsm

/* File: verilog/lpddr2_power_state.sv */
// Device power state and per-bank state tracking for a low-power DDR2 memory
`timescale 1ns/1ps
`include "lpddr2_state_defines.svh"
module lpddr2_power_state (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic mem_ck,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic [3:0] cmd,
	input wire logic [`BANK_W-1:0] bank,
	input wire logic auto_pre,
	input wire logic pre_all,
	input wire logic init_done,
	output lpddr2_state_pkg::dev_state_t dev_state,
	output logic [`NUM_BANKS*8-1:0] bank_states,
	output logic all_idle,
	output logic cmd_error
);
	// Two-flop synchronisers; only the second stage is read
	logic [3:0] pin_s1_r, pin_s2_r;
	logic [3:0] cmd_s1_r, cmd_s2_r;
	logic [`BANK_W-1:0] bank_s1_r, bank_s2_r;
	logic ck_prev_r, cke_prev_r;
	lpddr2_state_pkg::dev_state_t dev_r, dev_nxt, ret_r, ret_nxt;
	logic [`CNT_W-1:0] tmr_r, tmr_nxt;
	logic err_r, err_nxt;
	logic [`BANK_W-1:0] last_bank_r, last_bank_nxt;
	logic ck_tick, cke_s, cs_n_s, ap_s, pa_s, init_s, cmd_valid, bst_now;
	logic [`NUM_BANKS-1:0] bk_idle, bk_open, bk_burst;
	logic any_active;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_s1_r <= 4'h0;
			pin_s2_r <= 4'h0;
			cmd_s1_r <= 4'h0;
			cmd_s2_r <= 4'h0;
			bank_s1_r <= '0;
			bank_s2_r <= '0;
		end else begin
			pin_s1_r <= {mem_ck, cke, auto_pre, pre_all};
			pin_s2_r <= pin_s1_r;
			cmd_s1_r <= cmd;
			cmd_s2_r <= cmd_s1_r;
			bank_s1_r <= bank;
			bank_s2_r <= bank_s1_r;
		end
	end
	// CS and init are only sampled with CKE, so a shared sync is enough
	logic [1:0] ctl_s1_r, ctl_s2_r;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctl_s1_r <= 2'h3;
			ctl_s2_r <= 2'h3;
		end else begin
			ctl_s1_r <= {cs_n, init_done};
			ctl_s2_r <= ctl_s1_r;
		end
	end
	assign cke_s = pin_s2_r[2];
	assign ap_s = pin_s2_r[1];
	assign pa_s = pin_s2_r[0];
	assign cs_n_s = ctl_s2_r[1];
	assign init_s = ctl_s2_r[0];
	assign ck_tick = pin_s2_r[3] && !ck_prev_r;
	function automatic logic bank_busy(input lpddr2_state_pkg::bank_state_t s);
		bank_busy = (s == lpddr2_state_pkg::BK_PRECHARGING) ||
			(s == lpddr2_state_pkg::BK_ACTIVATING) ||
			(s == lpddr2_state_pkg::BK_AP_BURST) ||
			(s == lpddr2_state_pkg::BK_REFRESHING);
	endfunction
	// Bank commands pass only in a normal state with CKE high twice and exit time met
	assign cmd_valid = ck_tick && cke_prev_r && cke_s && !cs_n_s && tmr_r == '0 &&
		(dev_r == lpddr2_state_pkg::DEV_IDLE ||
		dev_r == lpddr2_state_pkg::DEV_ACTIVE);
	assign bst_now = cmd_valid && cmd_s2_r == `CMD_BST;
	genvar gi;
	generate
		for (gi = 0; gi < `NUM_BANKS; gi++) begin : g_bank
			lpddr2_state_pkg::bank_state_t st;
			logic cmd_ok;
			localparam logic [`BANK_W-1:0] bank_id = `BANK_W'(gi);
			// Commands other than burst stop are gated so busy banks never see them; per-bank refresh also needs an idle bank
			assign cmd_ok = cmd_valid && !bank_busy(st) &&
				!(cmd_s2_r == `CMD_REFPB && !bk_idle[gi]);
			lpddr2_bank_fsm u_bank (
				.sys_clk(sys_clk),
				.arst_n(arst_n),
				.ck_tick(ck_tick),
				.cmd_valid(cmd_ok),
				.sel(bank_s2_r == bank_id),
				.cmd(cmd_s2_r),
				.auto_pre(ap_s),
				.pre_all(pa_s),
				.bst_hit(bst_now && last_bank_r == bank_id),
				.state(st),
				.open_row(bk_open[gi])
			);
			assign bank_states[gi*8 +: 8] = st;
			assign bk_idle[gi] = (st == lpddr2_state_pkg::BK_IDLE);
			assign bk_burst[gi] = (st == lpddr2_state_pkg::BK_READING) ||
				(st == lpddr2_state_pkg::BK_WRITING) ||
				(st == lpddr2_state_pkg::BK_AP_BURST);
		end
	endgenerate
	assign all_idle = &bk_idle;
	assign any_active = |bk_open;
	assign dev_state = dev_r;
	assign cmd_error = err_r;
	always_comb begin
		dev_nxt = dev_r;
		ret_nxt = ret_r;
		tmr_nxt = tmr_r;
		err_nxt = 1'b0;
		last_bank_nxt = last_bank_r;
		if (ck_tick && tmr_r != '0)
			tmr_nxt = tmr_r - 1'b1;
		if (cmd_valid && (cmd_s2_r == `CMD_RD || cmd_s2_r == `CMD_WR))
			last_bank_nxt = bank_s2_r;
		if (ck_tick) begin
			case (dev_r)
				lpddr2_state_pkg::DEV_ACT_PD, lpddr2_state_pkg::DEV_IDLE_PD,
				lpddr2_state_pkg::DEV_RST_PD, lpddr2_state_pkg::DEV_SREF,
				lpddr2_state_pkg::DEV_DPD: begin
					// CKE low twice keeps the state whatever CS does
					if (!cke_prev_r && cke_s && cs_n_s) begin
						tmr_nxt = `T_XP_CK;
						case (dev_r)
							lpddr2_state_pkg::DEV_ACT_PD:
								dev_nxt = lpddr2_state_pkg::DEV_ACTIVE;
							lpddr2_state_pkg::DEV_IDLE_PD:
								dev_nxt = lpddr2_state_pkg::DEV_IDLE;
							lpddr2_state_pkg::DEV_RST_PD:
								dev_nxt = init_s ? lpddr2_state_pkg::DEV_IDLE :
									lpddr2_state_pkg::DEV_RESETTING;
							lpddr2_state_pkg::DEV_SREF: begin
								dev_nxt = lpddr2_state_pkg::DEV_IDLE;
								tmr_nxt = `T_XSR_CK;
							end
							default: begin
								dev_nxt = lpddr2_state_pkg::DEV_POWER_ON;
								tmr_nxt = '0;
							end
						endcase
					end else if (!cke_prev_r && cke_s)
						err_nxt = 1'b1;
				end
				lpddr2_state_pkg::DEV_IDLE, lpddr2_state_pkg::DEV_ACTIVE,
				lpddr2_state_pkg::DEV_RESETTING: begin
					if (cke_prev_r && !cke_s && cs_n_s) begin
						if (dev_r == lpddr2_state_pkg::DEV_RESETTING)
							dev_nxt = lpddr2_state_pkg::DEV_RST_PD;
						else if (any_active)
							dev_nxt = lpddr2_state_pkg::DEV_ACT_PD;
						else
							dev_nxt = lpddr2_state_pkg::DEV_IDLE_PD;
					end else if (cke_prev_r && !cke_s && all_idle &&
							dev_r == lpddr2_state_pkg::DEV_IDLE) begin
						if (cmd_s2_r == `CMD_SREF)
							dev_nxt = lpddr2_state_pkg::DEV_SREF;
						else if (cmd_s2_r == `CMD_DPD)
							dev_nxt = lpddr2_state_pkg::DEV_DPD;
						else
							err_nxt = 1'b1;
					end else if (cke_prev_r && cke_s && !cs_n_s && tmr_r == '0) begin
						if (cmd_s2_r == `CMD_MRR) begin
							ret_nxt = dev_r;
							dev_nxt = lpddr2_state_pkg::DEV_BUSY;
							tmr_nxt = `T_MRR_CK;
						end else if (cmd_s2_r == `CMD_MRW && all_idle &&
								dev_r != lpddr2_state_pkg::DEV_RESETTING) begin
							dev_nxt = lpddr2_state_pkg::DEV_MRW;
							tmr_nxt = `T_MRW_CK;
						end else if (cmd_s2_r == `CMD_RESET && all_idle) begin
							dev_nxt = lpddr2_state_pkg::DEV_RESETTING;
						end else if (cmd_s2_r == `CMD_REFAB && all_idle) begin
							ret_nxt = lpddr2_state_pkg::DEV_IDLE;
							dev_nxt = lpddr2_state_pkg::DEV_BUSY;
							tmr_nxt = `T_RFCAB_CK;
						end else if (cmd_s2_r == `CMD_MRW || cmd_s2_r == `CMD_RESET ||
								cmd_s2_r == `CMD_REFAB)
							err_nxt = 1'b1;
					end else if (cke_prev_r && !cke_s)
						err_nxt = 1'b1;
				end
				lpddr2_state_pkg::DEV_POWER_ON:
					if (cke_prev_r && cke_s && !cs_n_s && cmd_s2_r == `CMD_RESET)
						dev_nxt = lpddr2_state_pkg::DEV_RESETTING;
				lpddr2_state_pkg::DEV_MRW:
					if (tmr_r == '0)
						dev_nxt = lpddr2_state_pkg::DEV_IDLE;
				lpddr2_state_pkg::DEV_BUSY:
					if (tmr_r == '0)
						dev_nxt = ret_r;
				default: dev_nxt = lpddr2_state_pkg::DEV_POWER_ON;
			endcase
		end
		// Follows the banks every cycle, so an opened row shows without waiting a clock rise
		// Idle and Active follow the banks while in normal operation
		if (dev_nxt == lpddr2_state_pkg::DEV_IDLE && any_active)
			dev_nxt = lpddr2_state_pkg::DEV_ACTIVE;
		else if (dev_nxt == lpddr2_state_pkg::DEV_ACTIVE && !any_active)
			dev_nxt = lpddr2_state_pkg::DEV_IDLE;
	end
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			dev_r <= lpddr2_state_pkg::DEV_POWER_ON;
			ret_r <= lpddr2_state_pkg::DEV_IDLE;
			tmr_r <= '0;
			err_r <= 1'b0;
			last_bank_r <= '0;
			ck_prev_r <= 1'b0;
			cke_prev_r <= 1'b0;
		end else begin
			dev_r <= dev_nxt;
			ret_r <= ret_nxt;
			tmr_r <= tmr_nxt;
			err_r <= err_nxt;
			last_bank_r <= last_bank_nxt;
			ck_prev_r <= pin_s2_r[3];
			cke_prev_r <= ck_tick ? cke_s : cke_prev_r;
		end
	end
	a_pd_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ck_tick && !cke_prev_r && !cke_s && dev_r == lpddr2_state_pkg::DEV_SREF |=>
		dev_r == lpddr2_state_pkg::DEV_SREF)
		else $error("self refresh left with cke low");
	a_sref_exit: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ck_tick && !cke_prev_r && cke_s && cs_n_s &&
		dev_r == lpddr2_state_pkg::DEV_SREF |=> tmr_r == `T_XSR_CK)
		else $error("self refresh exit timer wrong");
	a_dpd_exit: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ck_tick && !cke_prev_r && cke_s && cs_n_s &&
		dev_r == lpddr2_state_pkg::DEV_DPD |=> dev_r == lpddr2_state_pkg::DEV_POWER_ON)
		else $error("deep power-down exit not to power on");
	a_pd_entry: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ck_tick && cke_prev_r && !cke_s && cs_n_s &&
		dev_r == lpddr2_state_pkg::DEV_RESETTING |=> dev_r == lpddr2_state_pkg::DEV_RST_PD)
		else $error("resetting power-down not entered");
	a_mrw_idle: assert property (@(posedge sys_clk) disable iff (!arst_n)
		$rose(dev_r == lpddr2_state_pkg::DEV_MRW) |-> $past(all_idle))
		else $error("mode write with banks open");
	a_bank_gate: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ck_tick && all_idle && (!cke_prev_r || !cke_s || tmr_r != '0) |=>
		all_idle)
		else $error("bank left idle outside cke high window");
	// Device-level exits and entries
	a_act_pd_exit: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ck_tick && !cke_prev_r && cke_s && cs_n_s && any_active &&
		dev_r == lpddr2_state_pkg::DEV_ACT_PD |=> dev_r == lpddr2_state_pkg::DEV_ACTIVE)
		else $error("active power-down exit not to active");
	a_idle_pd_exit: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ck_tick && !cke_prev_r && cke_s && cs_n_s &&
		dev_r == lpddr2_state_pkg::DEV_IDLE_PD |=> dev_r == lpddr2_state_pkg::DEV_IDLE)
		else $error("idle power-down exit not to idle");
	a_rst_exit_idle: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ck_tick && !cke_prev_r && cke_s && cs_n_s && init_s &&
		dev_r == lpddr2_state_pkg::DEV_RST_PD |=> dev_r == lpddr2_state_pkg::DEV_IDLE)
		else $error("resetting power-down exit not to idle");
	a_rst_exit_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ck_tick && !cke_prev_r && cke_s && cs_n_s && !init_s &&
		dev_r == lpddr2_state_pkg::DEV_RST_PD |=> dev_r == lpddr2_state_pkg::DEV_RESETTING)
		else $error("resetting power-down exit not to resetting");
	a_sref_entry: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ck_tick && cke_prev_r && !cke_s && !cs_n_s && all_idle && cmd_s2_r == `CMD_SREF &&
		dev_r == lpddr2_state_pkg::DEV_IDLE |=> dev_r == lpddr2_state_pkg::DEV_SREF)
		else $error("self refresh not entered");
	a_dpd_entry: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ck_tick && cke_prev_r && !cke_s && !cs_n_s && all_idle && cmd_s2_r == `CMD_DPD &&
		dev_r == lpddr2_state_pkg::DEV_IDLE |=> dev_r == lpddr2_state_pkg::DEV_DPD)
		else $error("deep power-down not entered");
	a_mrr_return: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ck_tick && tmr_r == '0 && dev_r == lpddr2_state_pkg::DEV_BUSY &&
		ret_r == lpddr2_state_pkg::DEV_RESETTING |=> dev_r == lpddr2_state_pkg::DEV_RESETTING)
		else $error("mode read did not return to resetting");
	a_reset_cmd: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ck_tick && cke_prev_r && cke_s && !cs_n_s && cmd_s2_r == `CMD_RESET &&
		dev_r == lpddr2_state_pkg::DEV_POWER_ON |=> dev_r == lpddr2_state_pkg::DEV_RESETTING)
		else $error("reset command did not start resetting");
endmodule // lpddr2_power_state

/* File: sim/lpddr2_ctrl_model.sv */
// Memory controller model driving the command pins of the state model
`timescale 1ns/1ps
`include "lpddr2_state_defines.svh"
module lpddr2_ctrl_model (
	input wire logic sys_clk,
	output logic mem_ck,
	output logic cke,
	output logic cs_n,
	output logic [3:0] cmd,
	output logic [`BANK_W-1:0] bank,
	output logic auto_pre,
	output logic pre_all
);
	// Free running, so every exit interval sees many toggles
	initial begin
		mem_ck = 1'h0;
		#3;
		forever #80 mem_ck = ~mem_ck;
	end
	initial begin
		cke = 1'h1;
		cs_n = 1'h1;
		cmd = 4'hF;
		bank = 3'h0;
		auto_pre = 1'h0;
		pre_all = 1'h0;
	end
	// Pins move in the low half of mem_ck, held across the rise
	task automatic send(input logic k, input logic c, input logic [3:0] op,
		input logic [`BANK_W-1:0] b, input logic ap, input logic pa);
		@(negedge mem_ck);
		@(posedge sys_clk);
		cke <= k;
		cs_n <= c;
		cmd <= op;
		bank <= b;
		auto_pre <= ap;
		pre_all <= pa;
		@(posedge mem_ck);
		// Covers sync depth plus the registered update
		repeat (6) @(posedge sys_clk);
	endtask
	// Deselect with a non-code pattern; nothing else while busy or exiting
	task automatic nops(input int n);
		repeat (n) send(1'h1, 1'h1, 4'hF, 3'h7, 1'h0, 1'h0);
	endtask
endmodule // lpddr2_ctrl_model

/* File: sim/lpddr2_power_state_bench.sv */
// Self-checking bench for the power and bank state model
`timescale 1ns/1ps
`include "lpddr2_state_defines.svh"
module lpddr2_power_state_bench;
	logic sys_clk = 1'h0;
	logic arst_n = 1'h0;
	logic init_done = 1'h0;
	int err_pulses = 0;
	logic mem_ck, cke, cs_n, auto_pre, pre_all, all_idle, cmd_error;
	logic [3:0] cmd;
	logic [`BANK_W-1:0] bank;
	logic [`NUM_BANKS*8-1:0] bank_states;
	lpddr2_state_pkg::dev_state_t dev_state;
	int err_total = 0;
	int samples_checked = 0;
	always #4 sys_clk = ~sys_clk;
	lpddr2_ctrl_model i_lpddr2_ctrl_model (.sys_clk(sys_clk), .mem_ck(mem_ck), .cke(cke),
		.cs_n(cs_n), .cmd(cmd), .bank(bank), .auto_pre(auto_pre), .pre_all(pre_all));
	lpddr2_power_state i_lpddr2_power_state (.sys_clk(sys_clk), .arst_n(arst_n),
		.mem_ck(mem_ck), .cke(cke), .cs_n(cs_n), .cmd(cmd), .bank(bank), .auto_pre(auto_pre),
		.pre_all(pre_all), .init_done(init_done), .dev_state(dev_state),
		.bank_states(bank_states), .all_idle(all_idle), .cmd_error(cmd_error));
	// Error is a one-cycle pulse, so count every one
	always @(posedge sys_clk) begin
		if (cmd_error === 1'h1) begin
			err_pulses++;
		end
	end
	function automatic logic [10:0] bk(input int n);
		return {3'h0, bank_states[8*n+:8]};
	endfunction
	task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic c(input logic [3:0] op, input logic [2:0] b, input logic ap);
		i_lpddr2_ctrl_model.send(1'h1, 1'h0, op, b, ap, 1'h0);
	endtask
	task automatic pin(input logic k, input logic cs);
		i_lpddr2_ctrl_model.send(k, cs, 4'hF, 3'h7, 1'h0, 1'h0);
	endtask
	task automatic nop(input int n);
		i_lpddr2_ctrl_model.nops(n);
	endtask
	task automatic t_init();
		chk(dev_state, lpddr2_state_pkg::DEV_POWER_ON, "reset state");
		chk(bk(5), lpddr2_state_pkg::BK_IDLE, "bank at reset");
		chk({10'h0, all_idle}, 11'h001, "all idle at reset");
		c(`CMD_RESET, 3'h0, 1'h0);
		chk(dev_state, lpddr2_state_pkg::DEV_RESETTING, "reset cmd");
		c(`CMD_MRR, 3'h0, 1'h0);
		chk(dev_state, lpddr2_state_pkg::DEV_BUSY, "mrr in resetting");
		nop(3);
		chk(dev_state, lpddr2_state_pkg::DEV_RESETTING, "mrr return");
		pin(1'h0, 1'h1);
		chk(dev_state, lpddr2_state_pkg::DEV_RST_PD, "resetting pd");
		i_lpddr2_ctrl_model.send(1'h0, 1'h0, `CMD_ACT, 3'h1, 1'h0, 1'h0);
		chk(dev_state, lpddr2_state_pkg::DEV_RST_PD, "pd held");
		chk(bk(1), lpddr2_state_pkg::BK_IDLE, "act ignored in pd");
		pin(1'h1, 1'h1);
		chk(dev_state, lpddr2_state_pkg::DEV_RESETTING, "exit before init");
		nop(3);
		pin(1'h0, 1'h1);
		init_done <= 1'h1;
		pin(1'h1, 1'h1);
		chk(dev_state, lpddr2_state_pkg::DEV_IDLE, "exit after init");
		nop(3);
		$display("test init done");
	endtask
	task automatic t_bank();
		c(`CMD_ACT, 3'h2, 1'h0);
		chk(bk(2), lpddr2_state_pkg::BK_ACTIVATING, "activating");
		chk(dev_state, lpddr2_state_pkg::DEV_ACTIVE, "dev active");
		nop(3);
		chk(bk(2), lpddr2_state_pkg::BK_ACTIVATING, "trcd not met");
		nop(1);
		chk(bk(2), lpddr2_state_pkg::BK_ACTIVE, "trcd met");
		c(`CMD_RD, 3'h2, 1'h0);
		chk(bk(2), lpddr2_state_pkg::BK_READING, "read");
		c(`CMD_WR, 3'h2, 1'h0);
		chk(bk(2), lpddr2_state_pkg::BK_WRITING, "write after read");
		c(`CMD_RD, 3'h2, 1'h0);
		chk(bk(2), lpddr2_state_pkg::BK_READING, "read after write");
		c(`CMD_BST, 3'h5, 1'h0);
		chk(bk(2), lpddr2_state_pkg::BK_ACTIVE, "burst stop");
		pin(1'h0, 1'h1);
		chk(dev_state, lpddr2_state_pkg::DEV_ACT_PD, "active pd");
		pin(1'h1, 1'h1);
		chk(dev_state, lpddr2_state_pkg::DEV_ACTIVE, "active pd exit");
		nop(3);
		c(`CMD_ACT, 3'h3, 1'h0);
		nop(4);
		i_lpddr2_ctrl_model.send(1'h1, 1'h0, `CMD_PRE, 3'h0, 1'h0, 1'h1);
		chk(bk(2), lpddr2_state_pkg::BK_PRECHARGING, "pre all b2");
		chk(bk(3), lpddr2_state_pkg::BK_PRECHARGING, "pre all b3");
		nop(4);
		chk(bk(3), lpddr2_state_pkg::BK_IDLE, "trp met");
		chk({10'h0, all_idle}, 11'h001, "all idle again");
		pin(1'h0, 1'h1);
		chk(dev_state, lpddr2_state_pkg::DEV_IDLE_PD, "idle pd");
		pin(1'h1, 1'h1);
		chk(dev_state, lpddr2_state_pkg::DEV_IDLE, "idle pd exit");
		nop(3);
		$display("test bank done");
	endtask
	task automatic t_ap_mode();
		int err_base;
		c(`CMD_ACT, 3'h1, 1'h0);
		nop(4);
		c(`CMD_WR, 3'h1, 1'h1);
		chk(bk(1), lpddr2_state_pkg::BK_AP_BURST, "ap burst");
		c(`CMD_PRE, 3'h1, 1'h0);
		chk(bk(1), lpddr2_state_pkg::BK_AP_BURST, "ap not interrupted");
		nop(7);
		chk(bk(1), lpddr2_state_pkg::BK_IDLE, "ap done");
		c(`CMD_ACT, 3'h4, 1'h0);
		nop(4);
		err_base = err_pulses;
		c(`CMD_MRW, 3'h0, 1'h0);
		chk({10'h0, err_pulses > err_base}, 11'h001, "mrw with open row");
		c(`CMD_PRE, 3'h4, 1'h0);
		nop(4);
		c(`CMD_MRW, 3'h0, 1'h0);
		chk(dev_state, lpddr2_state_pkg::DEV_MRW, "mrw");
		nop(6);
		chk(dev_state, lpddr2_state_pkg::DEV_IDLE, "mrw done");
		c(`CMD_REFPB, 3'h6, 1'h0);
		chk(bk(6), lpddr2_state_pkg::BK_REFRESHING, "refresh bank");
		nop(16);
		chk(bk(6), lpddr2_state_pkg::BK_IDLE, "refresh done");
		c(`CMD_REFAB, 3'h0, 1'h0);
		chk(dev_state, lpddr2_state_pkg::DEV_BUSY, "refresh all");
		nop(33);
		chk(dev_state, lpddr2_state_pkg::DEV_IDLE, "refresh all done");
		$display("test ap and mode done");
	endtask
	task automatic t_sref();
		i_lpddr2_ctrl_model.send(1'h0, 1'h0, `CMD_SREF, 3'h0, 1'h0, 1'h0);
		chk(dev_state, lpddr2_state_pkg::DEV_SREF, "sref entry");
		pin(1'h0, 1'h0);
		chk(dev_state, lpddr2_state_pkg::DEV_SREF, "sref held");
		pin(1'h1, 1'h1);
		chk(dev_state, lpddr2_state_pkg::DEV_IDLE, "sref exit");
		nop(16);
		i_lpddr2_ctrl_model.send(1'h0, 1'h0, `CMD_DPD, 3'h0, 1'h0, 1'h0);
		chk(dev_state, lpddr2_state_pkg::DEV_DPD, "dpd entry");
		pin(1'h1, 1'h1);
		chk(dev_state, lpddr2_state_pkg::DEV_POWER_ON, "dpd exit");
		$display("test power modes done");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge sys_clk);
		arst_n <= 1'h1;
		repeat (4) @(posedge sys_clk);
		t_init();
		t_bank();
		t_ap_mode();
		t_sref();
		tally_and_finish();
	end
	// About 150 commands at one mem_ck period each, with wide margin
	initial begin
		#200000;
		err_total++;
		$display("MISMATCH %0t watchdog expired", $time);
		tally_and_finish();
	end
endmodule // lpddr2_power_state_bench
